/* rtl/gp_pkg.sv */
package gp_pkg;
	// port geometry
	localparam int GP_LINES = 26;
	localparam int GP_AW = 8;
	localparam int GP_FN_W = 3;
	localparam int GP_FN_STRIDE = 4;
	localparam int GP_FN_PER_WORD = 8;
	localparam int GP_SEL_WORDS = 4;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] GP_OFF_PORT_DATA = 8'h00;
	localparam logic [7:0] GP_OFF_OUTPUT_ENABLE = 8'h04;
	localparam logic [7:0] GP_OFF_PULL_ENABLE = 8'h08;
	localparam logic [7:0] GP_OFF_DRIVE_STRENGTH = 8'h0C;
	localparam logic [7:0] GP_OFF_IRQ_SENSE = 8'h10;
	localparam logic [7:0] GP_OFF_IRQ_BOTH_EDGES = 8'h14;
	localparam logic [7:0] GP_OFF_IRQ_POLARITY = 8'h18;
	localparam logic [7:0] GP_OFF_IRQ_MASK = 8'h1C;
	localparam logic [7:0] GP_OFF_IRQ_RAW_STATUS = 8'h20;
	localparam logic [7:0] GP_OFF_IRQ_MASKED_STATUS = 8'h24;
	localparam logic [7:0] GP_OFF_IRQ_CLEAR = 8'h28;
	localparam logic [7:0] GP_OFF_FUNC_SELECT_LINES_0_7 = 8'h2C;
	localparam logic [7:0] GP_OFF_FUNC_SELECT_LINES_8_15 = 8'h30;
	localparam logic [7:0] GP_OFF_FUNC_SELECT_LINES_16_23 = 8'h34;
	localparam logic [7:0] GP_OFF_FUNC_SELECT_LINES_24_25 = 8'h38;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [31:0] GP_RST_PORT_DATA = 32'h0000_0000;
	localparam logic [31:0] GP_RST_OUTPUT_ENABLE = 32'h0000_0000;
	localparam logic [31:0] GP_RST_PULL_ENABLE = 32'h003F_FFFF;
	localparam logic [31:0] GP_RST_DRIVE_STRENGTH = 32'h0000_0000;
	localparam logic [31:0] GP_RST_IRQ = 32'h0000_0000;
	localparam logic [31:0] GP_RST_SEL0 = 32'h0000_0000;
	localparam logic [31:0] GP_RST_SEL1 = 32'h0000_0110;
	localparam logic [31:0] GP_RST_SEL2 = 32'h0000_0000;
	localparam logic [31:0] GP_RST_SEL3 = 32'h0000_0000;
	localparam logic [31:0] GP_SEL3_MASK = 32'h0000_007F;
	localparam logic [31:0] GP_ZERO = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// function codes
	localparam logic [2:0] GP_FN_GPIO = 3'h0;
	localparam logic [2:0] GP_FN_SECOND_SERIAL = 3'h1;
	localparam logic [2:0] GP_FN_FIRST_SERIAL = 3'h4;
	localparam logic [2:0] GP_FN_THIRD_SERIAL = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [GP_LINES-1:0] out;
		logic [GP_LINES-1:0] oe;
	} gp_ser_t;

	typedef struct packed {
		logic [GP_LINES-1:0] out;
		logic [GP_LINES-1:0] oe;
		logic [GP_LINES-1:0] pull_en;
		logic [GP_LINES-1:0] drive_high;
	} gp_pad_t;

	typedef struct packed {
		logic [GP_LINES-1:0] sense;
		logic [GP_LINES-1:0] both_edges;
		logic [GP_LINES-1:0] polarity;
	} gp_irq_cfg_t;
endpackage

/* rtl/gp_line_det.sv */
`timescale 1ns/1ps
module gp_line_det #(
	parameter int W = 26
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pins and detector setup
	input wire logic [W-1:0] pin_raw,
	input wire logic [W-1:0] sense,
	input wire logic [W-1:0] both_edges,
	input wire logic [W-1:0] polarity,
	// results
	output logic [W-1:0] pin_sync,
	output logic [W-1:0] event_hit
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	logic [W-1:0] edge_hit;
	logic [W-1:0] level_hit;

	////////////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edges compare successive synced samples
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
	assign edge_hit = both_edges & (rise | fall)
		| ~both_edges & (polarity & rise | ~polarity & fall);
	assign level_hit = polarity & sync_q | ~polarity & ~sync_q;
	assign event_hit = sense & level_hit | ~sense & edge_hit;
	assign pin_sync = sync_q;
endmodule

/* rtl/gp_port.sv */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Contract
// - port data bit drives its line only in GPIO mode with output enabled.
// - port data reads return the synchronised pin levels.
// - output enable bit per line, 1 output, resets all zero.
// - pull enable bit per line, 1 on, resets pulled on for lines 0 to 21, off for lines 22 to 25.
// - drive strength bit per line, 1 high drive, resets zero.
// - sense bit per line, 0 edge detect, 1 level detect.
// - edge select bit, 0 single edge, 1 both edges.
// - polarity bit, 0 falling or low, 1 rising or high.
// - mask bit per line, 1 lets interrupt through, resets zero.
// - raw status sets when line matches its condition; read only.
// - writing 1 to clear register clears raw bit; 0 no effect.
// - clearing a masked line also drops its masked status bit.
// - masked status is read only, one bit per line, resets zero.
// - 3-bit function fields, eight per word at 4-bit stride.
// - second selector word resets lines 9 and 10 to 1.
// - fourth selector word holds lines 24 and 25; bits 31:7 zero.
// - codes 000 GPIO, 001 second, 100 first, 101 third serial.
module gp_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gp_pkg::GP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// package pins
	input wire logic [gp_pkg::GP_LINES-1:0] pad_in,
	output gp_pkg::gp_pad_t pad_o,
	// on-chip serial functions
	input wire gp_pkg::gp_ser_t first_serial_function,
	input wire gp_pkg::gp_ser_t second_serial_function,
	input wire gp_pkg::gp_ser_t third_serial_function,
	output logic [gp_pkg::GP_LINES-1:0] periph_in,
	// interrupt request
	output logic irq
);
	localparam int N = gp_pkg::GP_LINES;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic hit(input logic [gp_pkg::GP_AW-1:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [31:0] widen(input logic [N-1:0] v);
		widen = {{(32-N){1'b0}}, v};
	endfunction

	function automatic logic [2:0] fn_of(input logic [31:0] w,
		input int slot);
		fn_of = w[slot*gp_pkg::GP_FN_STRIDE +: gp_pkg::GP_FN_W];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state
	logic [N-1:0] data_q;
	logic [N-1:0] out_en_q;
	logic [N-1:0] pull_q;
	logic [N-1:0] drv_q;
	gp_pkg::gp_irq_cfg_t cfg_q;
	logic [N-1:0] mask_q;
	logic [N-1:0] raw_q;
	logic [N-1:0] raw_d;
	logic [N-1:0] masked;
	logic [31:0] sel_q [gp_pkg::GP_SEL_WORDS];
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic pslverr_q;
	logic err_d;
	logic wr_en;
	logic rd_setup;
	logic [N-1:0] clr;
	logic [N-1:0] pin_sync;
	logic [N-1:0] event_hit;
	logic [N-1:0] wdat;

	////////////////////////////////////////////////////////////////////////
	// bus phases; zero wait states, writes land on the access edge
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign wdat = pwdata[N-1:0];
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////
	// plain control registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= gp_pkg::GP_RST_PORT_DATA[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_PORT_DATA)) begin
			data_q <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_en_q <= gp_pkg::GP_RST_OUTPUT_ENABLE[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_OUTPUT_ENABLE)) begin
			out_en_q <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pull_q <= gp_pkg::GP_RST_PULL_ENABLE[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_PULL_ENABLE)) begin
			pull_q <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv_q <= gp_pkg::GP_RST_DRIVE_STRENGTH[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_DRIVE_STRENGTH)) begin
			drv_q <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// detector setup
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q.sense <= gp_pkg::GP_RST_IRQ[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_IRQ_SENSE)) begin
			cfg_q.sense <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q.both_edges <= gp_pkg::GP_RST_IRQ[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_IRQ_BOTH_EDGES)) begin
			cfg_q.both_edges <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q.polarity <= gp_pkg::GP_RST_IRQ[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_IRQ_POLARITY)) begin
			cfg_q.polarity <= wdat;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= gp_pkg::GP_RST_IRQ[N-1:0];
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_IRQ_MASK)) begin
			mask_q <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin sync and event detection
	gp_line_det #(
		.W(N)
	) u_det (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin_raw(pad_in),
		.sense(cfg_q.sense),
		.both_edges(cfg_q.both_edges),
		.polarity(cfg_q.polarity),
		.pin_sync(pin_sync),
		.event_hit(event_hit)
	);

	assign periph_in = pin_sync;

	////////////////////////////////////////////////////////////////////////
	// raw status; a new event beats a clear in the same cycle
	assign clr = (wr_en && hit(paddr, gp_pkg::GP_OFF_IRQ_CLEAR)) ? wdat : '0;

	always_comb begin
		raw_d = (raw_q & ~clr) | event_hit;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= gp_pkg::GP_RST_IRQ[N-1:0];
		end else begin
			raw_q <= raw_d;
		end
	end

	// no separate storage, so a clear drops the masked bit too
	assign masked = raw_q & mask_q;
	assign irq = |masked;

	////////////////////////////////////////////////////////////////////////
	// function selectors; reserved bits stored as written, except bits 31:7 of the fourth word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q[0] <= gp_pkg::GP_RST_SEL0;
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_FUNC_SELECT_LINES_0_7)) begin
			sel_q[0] <= pwdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q[1] <= gp_pkg::GP_RST_SEL1;
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_FUNC_SELECT_LINES_8_15)) begin
			sel_q[1] <= pwdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q[2] <= gp_pkg::GP_RST_SEL2;
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_FUNC_SELECT_LINES_16_23)) begin
			sel_q[2] <= pwdata;
		end
	end

	// only lines 24 and 25 exist here; bits 31:7 read zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q[3] <= gp_pkg::GP_RST_SEL3;
		end else if (wr_en && hit(paddr, gp_pkg::GP_OFF_FUNC_SELECT_LINES_24_25)) begin
			sel_q[3] <= pwdata & gp_pkg::GP_SEL3_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pad routing; undefined codes leave the line floating as input
	always_comb begin
		pad_o.pull_en = pull_q;
		pad_o.drive_high = drv_q;
		pad_o.out = '0;
		pad_o.oe = '0;
		for (int i = 0; i < N; i++) begin
			case (fn_of(sel_q[i / gp_pkg::GP_FN_PER_WORD], i % gp_pkg::GP_FN_PER_WORD))
				gp_pkg::GP_FN_GPIO: begin
					pad_o.out[i] = data_q[i] & out_en_q[i];
					pad_o.oe[i] = out_en_q[i];
				end
				gp_pkg::GP_FN_SECOND_SERIAL: begin
					pad_o.out[i] = second_serial_function.out[i];
					pad_o.oe[i] = second_serial_function.oe[i];
				end
				gp_pkg::GP_FN_FIRST_SERIAL: begin
					pad_o.out[i] = first_serial_function.out[i];
					pad_o.oe[i] = first_serial_function.oe[i];
				end
				gp_pkg::GP_FN_THIRD_SERIAL: begin
					pad_o.out[i] = third_serial_function.out[i];
					pad_o.oe[i] = third_serial_function.oe[i];
				end
				default: begin
					pad_o.out[i] = 1'b0;
					pad_o.oe[i] = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux, captured in the setup cycle
	always_comb begin
		rd_d = gp_pkg::GP_ZERO;
		err_d = 1'b0;
		case (paddr)
			gp_pkg::GP_OFF_PORT_DATA: begin
				rd_d = widen(pin_sync);
			end
			gp_pkg::GP_OFF_OUTPUT_ENABLE: begin
				rd_d = widen(out_en_q);
			end
			gp_pkg::GP_OFF_PULL_ENABLE: begin
				rd_d = widen(pull_q);
			end
			gp_pkg::GP_OFF_DRIVE_STRENGTH: begin
				rd_d = widen(drv_q);
			end
			gp_pkg::GP_OFF_IRQ_SENSE: begin
				rd_d = widen(cfg_q.sense);
			end
			gp_pkg::GP_OFF_IRQ_BOTH_EDGES: begin
				rd_d = widen(cfg_q.both_edges);
			end
			gp_pkg::GP_OFF_IRQ_POLARITY: begin
				rd_d = widen(cfg_q.polarity);
			end
			gp_pkg::GP_OFF_IRQ_MASK: begin
				rd_d = widen(mask_q);
			end
			gp_pkg::GP_OFF_IRQ_RAW_STATUS: begin
				rd_d = widen(raw_q);
			end
			gp_pkg::GP_OFF_IRQ_MASKED_STATUS: begin
				rd_d = widen(masked);
			end
			gp_pkg::GP_OFF_IRQ_CLEAR: begin
				rd_d = gp_pkg::GP_ZERO;
			end
			gp_pkg::GP_OFF_FUNC_SELECT_LINES_0_7: begin
				rd_d = sel_q[0];
			end
			gp_pkg::GP_OFF_FUNC_SELECT_LINES_8_15: begin
				rd_d = sel_q[1];
			end
			gp_pkg::GP_OFF_FUNC_SELECT_LINES_16_23: begin
				rd_d = sel_q[2];
			end
			gp_pkg::GP_OFF_FUNC_SELECT_LINES_24_25: begin
				rd_d = sel_q[3];
			end
			default: begin
				rd_d = gp_pkg::GP_ZERO;
				err_d = 1'b1;
			end
		endcase
	end

	// data is one cycle old at the access edge, a trade for a flopped bus
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= gp_pkg::GP_ZERO;
			pslverr_q <= 1'b0;
		end else if (rd_setup) begin
			prdata_q <= pwrite ? gp_pkg::GP_ZERO : rd_d;
			pslverr_q <= err_d;
		end else begin
			pslverr_q <= 1'b0;
		end
	end
endmodule

/* verif/gp_port_chk.sv */
`timescale 1ns/1ps
module gp_port_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// pins and request
	input wire logic [25:0] pad_in,
	input wire gp_pkg::gp_pad_t pad_o,
	input wire gp_pkg::gp_ser_t second_serial_function,
	input wire logic [25:0] periph_in,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic rd;
	logic wr;
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite;
	////////////////////////////////////////////////////////////////////////
	AST_PULL_RST: assert property ($rose(rst_n) |-> pad_o.pull_en == 26'h03FFFFF)
		else $error("pull enable not on after reset");
	// lines 9 and 10 leave reset owned by a serial function
	AST_OE_RST: assert property ($rose(rst_n) |-> (pad_o.oe & 26'h3FFF9FF) == 26'h0)
		else $error("gpio line driven after reset");
	AST_DRIVE_RST: assert property ($rose(rst_n) |-> pad_o.drive_high == 26'h0)
		else $error("drive strength not low after reset");
	AST_IRQ_RST: assert property ($rose(rst_n) |-> !irq)
		else $error("request high after reset");
	AST_SER_RST: assert property ($rose(rst_n) |-> pad_o.oe[10:9] ==
		second_serial_function.oe[10:9] && pad_o.out[10:9] ==
		second_serial_function.out[10:9])
		else $error("lines 9 and 10 not on second serial function");
	AST_MASK_OFF: assert property (wr && paddr == 8'h1C && pwdata == 32'h0 |=> !irq)
		else $error("request with all lines masked");
	AST_READ_PIN: assert property (rd && paddr == 8'h00 |-> prdata[25:0] == $past(pad_in, 3))
		else $error("port data read not pin level");
	AST_SYNC: assert property ($past(rst_n, 2) |-> periph_in == $past(pad_in, 2))
		else $error("pin sync latency wrong");
	AST_SEL3: assert property (rd && paddr == 8'h38 |-> prdata[31:7] == 25'h0)
		else $error("reserved selector bits not zero");
	AST_MASKED_WIDTH: assert property (rd && paddr == 8'h24 |-> prdata[31:26] == 6'h0)
		else $error("masked status beyond line count");
	////////////////////////////////////////////////////////////////////////
	cover property ($rose(irq));
	cover property (rd && paddr == 8'h00);
	cover property (wr && paddr == 8'h28);
endmodule
bind gp_port gp_port_chk gp_port_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pad_in(pad_in), .pad_o(pad_o), .second_serial_function(second_serial_function),
	.periph_in(periph_in), .irq(irq));

/* verif/gp_pins.sv */
`timescale 1ns/1ps
module gp_pins #(
	parameter logic PULL_LVL = 1'b1
) (
	// clock
	input wire logic sys_clk,
	// device side
	input wire gp_pkg::gp_pad_t pad_o,
	output logic [25:0] pad_in,
	output gp_pkg::gp_ser_t ser_a,
	output gp_pkg::gp_ser_t ser_b,
	output gp_pkg::gp_ser_t ser_c,
	// outside driver
	input wire logic [25:0] ext_en,
	input wire logic [25:0] ext_val
);
	// a floating line flips so it never reads as a steady level
	logic [25:0] flip_q = 26'h0;
	always_ff @(posedge sys_clk) begin
		flip_q <= ~pad_in;
	end
	// device drive wins over the outside, then outside, then pull
	assign pad_in = (pad_o.oe & pad_o.out) | (~pad_o.oe & ext_en & ext_val) |
		(~pad_o.oe & ~ext_en & pad_o.pull_en & {26{PULL_LVL}}) |
		(~pad_o.oe & ~ext_en & ~pad_o.pull_en & flip_q);
	// distinct patterns so each function is told apart on lines 1:0
	assign ser_a = {26'h3FFFFFF, 26'h3FFFFFF};
	assign ser_b = {26'h2AAAAAA, 26'h3FFFFFF};
	assign ser_c = {26'h1555555, 26'h3FFFFFF};
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [25:0] pad_in;
	logic [25:0] periph_in;
	logic [25:0] ext_en = 26'h3FFFFFF;
	logic [25:0] ext_val = 26'h3FFFFFF;
	gp_pkg::gp_pad_t pad_o;
	gp_pkg::gp_ser_t ser_a;
	gp_pkg::gp_ser_t ser_b;
	gp_pkg::gp_ser_t ser_c;
	logic irq;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] d;
	logic e;
	// {code, lines 1:0 level}
	logic [4:0] modes [5] = '{5'h00, 5'h13, 5'h06, 5'h15, 5'h0B};
	// {sense, both, polarity, line 2 level, request}
	logic [4:0] steps [8] = '{5'h04, 5'h07, 5'h01, 5'h0B, 5'h02, 5'h17, 5'h12, 5'h11};
	initial forever #20 sys_clk = ~sys_clk;
	gp_port gp_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_in(pad_in), .pad_o(pad_o), .first_serial_function(ser_a),
		.second_serial_function(ser_b), .third_serial_function(ser_c),
		.periph_in(periph_in), .irq(irq));
	gp_pins gp_pins_i (.sys_clk(sys_clk), .pad_o(pad_o), .pad_in(pad_in), .ser_a(ser_a),
		.ser_b(ser_b), .ser_c(ser_c), .ext_en(ext_en), .ext_val(ext_val));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	// idle edge first, so back to back calls never reassign in one step
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		cmp(n, d & m, x);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 1; i < 15; i++) begin
			rdc("reset", 8'(i * 4), 32'hFFFFFFFF, i == 2 ? 32'h3FFFFF : i == 12 ? 32'h110 : 32'h0);
		end
		xfer(1'b0, 8'h3C, 32'h0);
		cmp("unmapped", {31'h0, e}, 32'h1);
		xfer(1'b1, 8'h04, 32'h3);
		for (int k = 0; k < 5; k++) begin
			xfer(1'b1, 8'h2C, {25'h0, modes[k][4:2], 1'b0, modes[k][4:2]});
			repeat (3) @(posedge sys_clk);
			if (k < 4) cmp("pin out", pad_o.out[1:0], modes[k][1:0]);
			cmp("pin oe", pad_o.oe[1:0], k == 4 ? 2'h0 : 2'h3);
			cmp("sync in", periph_in[1:0], modes[k][1:0]);
			rdc("pin read", 8'h00, 32'h3, modes[k][1:0]);
		end
		xfer(1'b1, 8'h2C, 32'h0);
		xfer(1'b1, 8'h00, 32'h3);
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h0C, 32'h3FFFFFF);
		repeat (3) @(posedge sys_clk);
		cmp("gpio out", pad_o.out[1:0], 2'h3);
		cmp("pull", pad_o.pull_en, 26'h0);
		cmp("drive", pad_o.drive_high, 26'h3FFFFFF);
		xfer(1'b1, 8'h04, 32'h0);
		repeat (3) @(posedge sys_clk);
		cmp("input mode", pad_o.oe[1:0], 2'h0);
		// reserved selector bits are always written as zero
		xfer(1'b1, 8'h38, 32'h0000_0055);
		rdc("sel3", 8'h38, 32'hFFFFFFFF, 32'h0000_0055);
		xfer(1'b1, 8'h28, 32'h3FFFFFF);
		xfer(1'b1, 8'h1C, 32'h4);
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, 8'h10, {29'h0, steps[k][4], 2'h0});
			xfer(1'b1, 8'h14, {29'h0, steps[k][3], 2'h0});
			xfer(1'b1, 8'h18, {29'h0, steps[k][2], 2'h0});
			xfer(1'b1, 8'h28, 32'h4);
			ext_val[2] <= steps[k][1];
			repeat (4) @(posedge sys_clk);
			cmp("irq", irq, steps[k][0]);
		end
		xfer(1'b1, 8'h1C, 32'h0);
		xfer(1'b1, 8'h20, 32'h0);
		rdc("raw", 8'h20, 32'h4, 32'h4);
		rdc("masked off", 8'h24, 32'hFFFFFFFF, 32'h0);
		cmp("irq off", irq, 1'b0);
		xfer(1'b1, 8'h28, 32'h4);
		xfer(1'b1, 8'h1C, 32'h4);
		rdc("masked on", 8'h24, 32'hFFFFFFFF, 32'h4);
		xfer(1'b1, 8'h10, 32'h0);
		// edge mode keeps the bit sticky, so a zero write that clears would show
		xfer(1'b1, 8'h28, 32'h0);
		@(posedge sys_clk);
		cmp("clear zero", irq, 1'b1);
		xfer(1'b1, 8'h28, 32'h4);
		rdc("masked clr", 8'h24, 32'hFFFFFFFF, 32'h0);
		cmp("irq clr", irq, 1'b0);
		close_out();
	end
endmodule
